// ### lsuc_cfg.svh
// constants for the load/store unit control block
`ifndef LSUC_CFG_SVH
`define LSUC_CFG_SVH

// register port
`define LSUC_ADDR_W        8
`define LSUC_DATA_W        64
`define LSUC_ADDR_MCTL     8'h00
`define LSUC_ADDR_DCTL     8'h08
`define LSUC_ADDR_STAT     8'h10

// memory_unit_control field positions
`define LSUC_SMC_HI        5
`define LSUC_SMC_LO        4
`define LSUC_SPE_HI        3
`define LSUC_SPE_LO        1
`define LSUC_SMC_RST       2'h0
`define LSUC_SPE_RST       3'h0

// data_cache_control field positions
`define LSUC_DCHK_BIT      7
`define LSUC_TCHK_BIT      6
`define LSUC_BECC_BIT      5
`define LSUC_BTPAR_BIT     4
`define LSUC_FHIT_BIT      2
`define LSUC_SETEN_HI      1
`define LSUC_SETEN_LO      0
`define LSUC_SETEN_RST     2'h3
`define LSUC_SETEN_NONE    2'h0

// status readout layout
`define LSUC_STAT_CNT_HI   7
`define LSUC_STAT_CNT_LO   0
`define LSUC_STAT_CONS_BIT 8
`define LSUC_STAT_SMC_HI   10
`define LSUC_STAT_SMC_LO   9

// mispredict counter
`define LSUC_CNT_W         8
`define LSUC_CNT_RST       8'h00
`define LSUC_CNT_MAX       8'hff
`define LSUC_CNT_INC_SLOW  8'h04
`define LSUC_CNT_INC_FAST  8'h08
`define LSUC_CNT_DEC       8'h01

// superpage translation
`define LSUC_VA_W          48
`define LSUC_PFN_W         31
`define LSUC_SP2_TAG       2'h2
`define LSUC_SP1_TAG       7'h7e
`define LSUC_SP0_TAG       18'h3fffe
`define LSUC_SP0_ZERO      14'h0000
`define LSUC_VA_TAG_HI     47
`define LSUC_SP2_TAG_LO    46
`define LSUC_SP1_TAG_LO    41
`define LSUC_SP0_TAG_LO    30
`define LSUC_SP2_MAP_HI    43
`define LSUC_SP1_MAP_HI    40
`define LSUC_SP0_MAP_HI    29
`define LSUC_PAGE_LO       13
`define LSUC_SP1_EXT_W     3

`endif

// ### lsuc_pkg.sv
// types for the load/store unit control block
package lsuc_pkg;

  typedef enum logic [1:0] {
    LSUC_SMC_SPEC   = 2'h0,
    LSUC_SMC_CONS   = 2'h1,
    LSUC_SMC_PER4   = 2'h2,
    LSUC_SMC_PER8   = 2'h3
  } lsuc_smc_t;

  typedef struct packed {
    lsuc_smc_t    speculative_miss_control;
    logic [2:0]   superpage_enables;
    logic         data_chk;
    logic         tag_chk;
    logic         bad_ecc;
    logic         bad_tpar;
    logic         force_hit;
    logic [1:0]   set_en;
    logic [7:0]   cnt;
    logic         cons;
    logic [63:0]  rdata;
    logic         sp_hit;
    logic [30:0]  sp_pfn;
    logic         hit;
    logic [1:0]   hit_set;
    logic         store_offchip;
    logic         data_err;
    logic         tag_err;
    logic         data_we;
    logic         ecc_we;
    logic         tag_we;
    logic         tag_par;
  } lsuc_state_t;

endpackage

// ### lsuc_superpage.sv
// superpage virtual to physical mapping
`timescale 1ns/1ps
`include "lsuc_cfg.svh"

module lsuc_superpage (
  // request
  input  wire logic [`LSUC_VA_W-1:0]  va,
  input  wire logic [2:0]             superpage_enables,
  // result
  output logic                        match,
  output logic [`LSUC_PFN_W-1:0]      pfn
);

  always_comb
  begin
    match = 1'b0;
    pfn   = '0;
    if (superpage_enables[2] && va[`LSUC_VA_TAG_HI:`LSUC_SP2_TAG_LO] == `LSUC_SP2_TAG)
    begin
      match = 1'b1;
      pfn   = va[`LSUC_SP2_MAP_HI:`LSUC_PAGE_LO];
    end
    else if (superpage_enables[1] && va[`LSUC_VA_TAG_HI:`LSUC_SP1_TAG_LO] == `LSUC_SP1_TAG)
    begin
      match = 1'b1;
      pfn   = {{`LSUC_SP1_EXT_W{va[`LSUC_SP1_MAP_HI]}},
               va[`LSUC_SP1_MAP_HI:`LSUC_PAGE_LO]};
    end
    else if (superpage_enables[0] && va[`LSUC_VA_TAG_HI:`LSUC_SP0_TAG_LO] == `LSUC_SP0_TAG)
    begin
      match = 1'b1;
      pfn   = {`LSUC_SP0_ZERO, va[`LSUC_SP0_MAP_HI:`LSUC_PAGE_LO]};
    end
  end

endmodule

// ### lsuc_top.sv
// load/store unit control registers and cache control logic
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "lsuc_cfg.svh"

// Notes on behaviour
// - memory_unit_control is write-only; reset clears every field.
// - mode 00 speculates always, conservative mode never entered.
// - mode 01 holds conservative mode permanently, with its retry effects.
// - mode 10 adds four per mispredict, subtracts one per retired branch.
// - mode 11 adds eight per mispredict, subtracts one per retired branch.
// - periodic modes are conservative while counter top bit is set.
// - superpage 2 maps va 43:13 straight through, ignores va 45:44.
// - superpage 1 maps va 40:13, sign-extends bit 40 into 43:41.
// - superpage 0 maps va 29:13, clears physical bits 43:30.
// - set enables reset to both; an all-off write is refused, so one set stays enabled.
// - data check enable gates data ECC and parity error reports.
// - tag check enable gates tag parity error reports on probes.
// - bad-ECC inject writes data on fills and stores, keeps old ECC.
// - bad-parity inject writes wrong tag parity on every fill.
// - force-hit makes every memory-space load and store a hit.
// - force-hit never marks dirty; stores may still go off chip.
module lsuc_top (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // register port
  input  wire logic [`LSUC_ADDR_W-1:0]  reg_addr,
  input  wire logic [`LSUC_DATA_W-1:0]  reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [`LSUC_DATA_W-1:0]  reg_rdata,
  // branch events
  input  wire logic                     branch_mispredict,
  input  wire logic                     cond_branch_retire,
  // speculation mode
  output logic                          conservative_mode,
  output logic                          retry_at_retire,
  output logic                          store_nondirty_retry,
  output logic                          prefetch_modify_plain,
  // superpage translation
  input  wire logic                     va_valid,
  input  wire logic [`LSUC_VA_W-1:0]    va,
  output logic                          sp_hit,
  output logic      [`LSUC_PFN_W-1:0]   sp_pfn,
  // cache lookup
  input  wire logic                     lookup_valid,
  input  wire logic                     lookup_mem_space,
  input  wire logic                     lookup_store,
  input  wire logic [1:0]               tag_match,
  input  wire logic [1:0]               tag_dirty,
  input  wire logic                     tag_perr_in,
  input  wire logic                     data_err_in,
  output logic                          cache_hit,
  output logic      [1:0]               hit_set,
  output logic                          store_offchip,
  output logic                          tag_err_report,
  output logic                          data_err_report,
  // cache array writes
  input  wire logic                     fill_valid,
  input  wire logic                     store_write,
  input  wire logic                     tag_parity_in,
  output logic                          data_write_en,
  output logic                          ecc_write_en,
  output logic                          tag_write_en,
  output logic                          tag_parity_out
);

  lsuc_pkg::lsuc_state_t st_reg;
  lsuc_pkg::lsuc_state_t st_next;
  logic                    sp_match;
  logic [`LSUC_PFN_W-1:0]  sp_map;

  // saturating counter step
  function automatic logic [`LSUC_CNT_W-1:0] cnt_step(
    input logic [`LSUC_CNT_W-1:0] cnt,
    input logic [`LSUC_CNT_W-1:0] inc,
    input logic                   dec
  );
    logic [`LSUC_CNT_W:0] sum;
    logic [`LSUC_CNT_W:0] res;
    sum = {1'b0, cnt} + {1'b0, inc};
    res = sum;
    if (dec)
    begin
      if (sum == '0)
        res = '0;
      else
        res = sum - {1'b0, `LSUC_CNT_DEC};
    end
    if (res[`LSUC_CNT_W])
      cnt_step = `LSUC_CNT_MAX;
    else
      cnt_step = res[`LSUC_CNT_W-1:0];
  endfunction

  // status readout word
  function automatic logic [`LSUC_DATA_W-1:0] stat_word(
    input lsuc_pkg::lsuc_state_t s
  );
    logic [`LSUC_DATA_W-1:0] w;
    w = '0;
    w[`LSUC_STAT_CNT_HI:`LSUC_STAT_CNT_LO] = s.cnt;
    w[`LSUC_STAT_CONS_BIT] = s.cons;
    w[`LSUC_STAT_SMC_HI:`LSUC_STAT_SMC_LO] = s.speculative_miss_control;
    stat_word = w;
  endfunction

  lsuc_superpage u_superpage (
    .va    (va),
    .superpage_enables   (st_reg.superpage_enables),
    .match (sp_match),
    .pfn   (sp_map)
  );

  always_comb
  begin
    logic [`LSUC_CNT_W-1:0] inc;
    logic [1:0]             sets;
    logic                   mem_op;
    logic                   dirty;
    inc    = '0;
    sets   = '0;
    mem_op = 1'b0;
    dirty  = 1'b0;
    st_next = st_reg;

    // register writes; both registers are write-only
    if (reg_wr && reg_addr == `LSUC_ADDR_MCTL)
    begin
      st_next.speculative_miss_control = lsuc_pkg::lsuc_smc_t'(
        reg_wdata[`LSUC_SMC_HI:`LSUC_SMC_LO]);
      st_next.superpage_enables = reg_wdata[`LSUC_SPE_HI:`LSUC_SPE_LO];
    end
    if (reg_wr && reg_addr == `LSUC_ADDR_DCTL)
    begin
      st_next.data_chk  = reg_wdata[`LSUC_DCHK_BIT];
      st_next.tag_chk   = reg_wdata[`LSUC_TCHK_BIT];
      st_next.bad_ecc   = reg_wdata[`LSUC_BECC_BIT];
      st_next.bad_tpar  = reg_wdata[`LSUC_BTPAR_BIT];
      st_next.force_hit = reg_wdata[`LSUC_FHIT_BIT];
      // an all-off set mask is refused, the old mask stays
      if (reg_wdata[`LSUC_SETEN_HI:`LSUC_SETEN_LO] != `LSUC_SETEN_NONE)
        st_next.set_en = reg_wdata[`LSUC_SETEN_HI:`LSUC_SETEN_LO];
    end

    // read data valid the cycle after the strobe only
    st_next.rdata = '0;
    if (reg_rd && reg_addr == `LSUC_ADDR_STAT)
      st_next.rdata = stat_word(st_reg);

    // mispredict counter
    case (st_reg.speculative_miss_control)
      lsuc_pkg::LSUC_SMC_PER4:
      begin
        if (branch_mispredict)
          inc = `LSUC_CNT_INC_SLOW;
        st_next.cnt = cnt_step(st_reg.cnt, inc, cond_branch_retire);
      end
      lsuc_pkg::LSUC_SMC_PER8:
      begin
        if (branch_mispredict)
          inc = `LSUC_CNT_INC_FAST;
        st_next.cnt = cnt_step(st_reg.cnt, inc, cond_branch_retire);
      end
      default:
      begin
        st_next.cnt = st_reg.cnt;
      end
    endcase

    // speculation mode
    case (st_next.speculative_miss_control)
      lsuc_pkg::LSUC_SMC_SPEC:
        st_next.cons = 1'b0;
      lsuc_pkg::LSUC_SMC_CONS:
        st_next.cons = 1'b1;
      lsuc_pkg::LSUC_SMC_PER4,
      lsuc_pkg::LSUC_SMC_PER8:
        st_next.cons = st_next.cnt[`LSUC_CNT_W-1];
      default:
        st_next.cons = 1'b0;
    endcase

    // superpage result
    st_next.sp_hit = va_valid && sp_match;
    st_next.sp_pfn = sp_match ? sp_map : '0;

    // cache hit decision
    mem_op = lookup_valid && lookup_mem_space;
    if (st_reg.force_hit)
      sets = st_reg.set_en;
    else
      sets = tag_match & st_reg.set_en;
    st_next.hit     = mem_op && (st_reg.force_hit || sets != 2'h0);
    st_next.hit_set = mem_op ? sets : 2'h0;
    // dirty state still comes from the tags under force-hit
    dirty = (sets & tag_dirty) != 2'h0;
    st_next.store_offchip = st_next.hit && lookup_store && !dirty;

    // error reporting gates
    st_next.tag_err  = lookup_valid && st_reg.tag_chk && tag_perr_in;
    st_next.data_err = st_reg.data_chk && data_err_in;

    // array writes
    st_next.data_we = fill_valid || store_write;
    st_next.ecc_we  = st_next.data_we && !st_reg.bad_ecc;
    st_next.tag_we  = fill_valid;
    st_next.tag_par = fill_valid && (tag_parity_in ^ st_reg.bad_tpar);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg.speculative_miss_control           <= lsuc_pkg::LSUC_SMC_SPEC;
      st_reg.superpage_enables           <= `LSUC_SPE_RST;
      st_reg.data_chk      <= 1'b0;
      st_reg.tag_chk       <= 1'b0;
      st_reg.bad_ecc       <= 1'b0;
      st_reg.bad_tpar      <= 1'b0;
      st_reg.force_hit     <= 1'b0;
      st_reg.set_en        <= `LSUC_SETEN_RST;
      st_reg.cnt           <= `LSUC_CNT_RST;
      st_reg.cons          <= 1'b0;
      st_reg.rdata         <= '0;
      st_reg.sp_hit        <= 1'b0;
      st_reg.sp_pfn        <= '0;
      st_reg.hit           <= 1'b0;
      st_reg.hit_set       <= 2'h0;
      st_reg.store_offchip <= 1'b0;
      st_reg.data_err      <= 1'b0;
      st_reg.tag_err       <= 1'b0;
      st_reg.data_we       <= 1'b0;
      st_reg.ecc_we        <= 1'b0;
      st_reg.tag_we        <= 1'b0;
      st_reg.tag_par       <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata             = st_reg.rdata;
  assign conservative_mode     = st_reg.cons;
  assign retry_at_retire       = st_reg.cons;
  assign store_nondirty_retry  = st_reg.cons;
  assign prefetch_modify_plain = st_reg.cons;
  assign sp_hit                = st_reg.sp_hit;
  assign sp_pfn                = st_reg.sp_pfn;
  assign cache_hit             = st_reg.hit;
  assign hit_set               = st_reg.hit_set;
  assign store_offchip         = st_reg.store_offchip;
  assign tag_err_report        = st_reg.tag_err;
  assign data_err_report       = st_reg.data_err;
  assign data_write_en         = st_reg.data_we;
  assign ecc_write_en          = st_reg.ecc_we;
  assign tag_write_en          = st_reg.tag_we;
  assign tag_parity_out        = st_reg.tag_par;

endmodule

// ### lsuc_asserts.sv
// property checker for the load/store unit control block
`timescale 1ns/1ps
module lsuc_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [63:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [63:0] reg_rdata,
  // speculation mode
  input wire logic        conservative_mode,
  input wire logic        retry_at_retire,
  input wire logic        store_nondirty_retry,
  input wire logic        prefetch_modify_plain,
  // translation
  input wire logic        va_valid,
  input wire logic [47:0] va,
  input wire logic        sp_hit,
  input wire logic [30:0] sp_pfn,
  // cache lookup and writes
  input wire logic        lookup_valid,
  input wire logic        lookup_mem_space,
  input wire logic        lookup_store,
  input wire logic [1:0]  tag_dirty,
  input wire logic        data_err_in,
  input wire logic        cache_hit,
  input wire logic [1:0]  hit_set,
  input wire logic        store_offchip,
  input wire logic        data_err_report,
  input wire logic        data_write_en,
  input wire logic        ecc_write_en
);
  logic [47:0] va_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  always_ff @(posedge clk)
    va_q <= va;

  a_wo_read_zero: assert property (reg_rd && reg_addr != 8'h10
    |=> reg_rdata == 64'h0) else $error("write-only read not zero");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 64'h0)
    else $error("read data outside read slot");
  a_spec_mode: assert property (reg_wr && reg_addr == 8'h00
    && reg_wdata[5:4] == 2'h0 ##1 !reg_wr [*2] |-> !conservative_mode)
    else $error("conservative in speculative mode");
  a_cons_mode: assert property (reg_wr && reg_addr == 8'h00
    && reg_wdata[5:4] == 2'h1 ##1 !reg_wr [*2] |-> conservative_mode)
    else $error("not conservative in full-time mode");
  a_side_effects: assert property ({retry_at_retire,
    store_nondirty_retry, prefetch_modify_plain} == {3{conservative_mode}})
    else $error("retry controls disagree with mode");
  a_stat_cons: assert property (reg_rd && reg_addr == 8'h10 |=>
    reg_rdata[8] == (reg_rdata[10:9] == 2'h1
    || (reg_rdata[10] && reg_rdata[7]))) else $error("bad mode bit");
  a_sp2_map: assert property (sp_hit && va_q[47:46] == 2'h2
    |-> sp_pfn == va_q[43:13]) else $error("superpage 2 map");
  a_sp1_map: assert property (sp_hit && va_q[47:41] == 7'h7e |->
    sp_pfn == {{3{va_q[40]}}, va_q[40:13]}) else $error("superpage 1 map");
  a_sp0_map: assert property (sp_hit && va_q[47:30] == 18'h3fffe
    |-> sp_pfn == {14'h0, va_q[29:13]}) else $error("superpage 0 map");
  a_hit_mem_op: assert property (cache_hit |-> $past(lookup_valid)
    && $past(lookup_mem_space)) else $error("hit without memory op");
  a_offchip_clean: assert property (store_offchip |-> cache_hit
    && $past(lookup_store) && (hit_set & $past(tag_dirty)) == 2'h0)
    else $error("off-chip store on dirty hit");
  a_err_cause: assert property (data_err_report |-> $past(data_err_in))
    else $error("data error without cause");
  a_ecc_data: assert property (ecc_write_en |-> data_write_en)
    else $error("check bits written without data");

  cover property (sp_hit);
  cover property (conservative_mode);
  cover property (store_offchip);
endmodule

bind lsuc_top lsuc_asserts chk_u (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conservative_mode(conservative_mode), .retry_at_retire(retry_at_retire),
  .store_nondirty_retry(store_nondirty_retry),
  .prefetch_modify_plain(prefetch_modify_plain), .va_valid(va_valid),
  .va(va), .sp_hit(sp_hit), .sp_pfn(sp_pfn), .lookup_valid(lookup_valid),
  .lookup_mem_space(lookup_mem_space), .lookup_store(lookup_store),
  .tag_dirty(tag_dirty), .data_err_in(data_err_in), .cache_hit(cache_hit),
  .hit_set(hit_set), .store_offchip(store_offchip),
  .data_err_report(data_err_report), .data_write_en(data_write_en),
  .ecc_write_en(ecc_write_en));

// ### lsuc_tb.sv
// self-checking bench for the load/store unit control block
`timescale 1ns/1ps
module testbench;
  logic        clk, resetn, reg_wr, reg_rd, bm, cr, va_valid, sp_hit, cm;
  logic        rr, sr, pr, hit, off, terr, derr, dwe, ewe, twe, tpo;
  logic [1:0]  hs;
  logic [11:0] cin;
  logic [7:0]  reg_addr;
  logic [63:0] reg_wdata, reg_rdata;
  logic [47:0] va;
  logic [47:0] vas [3];
  logic [30:0] sp_pfn;
  logic [30:0] pf [3];
  int          err_total, num_checks;

  lsuc_top dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .branch_mispredict(bm), .cond_branch_retire(cr),
    .conservative_mode(cm), .retry_at_retire(rr), .store_nondirty_retry(sr),
    .prefetch_modify_plain(pr), .va_valid(va_valid), .va(va),
    .sp_hit(sp_hit), .sp_pfn(sp_pfn), .lookup_valid(cin[11]),
    .lookup_mem_space(cin[10]), .lookup_store(cin[9]),
    .tag_match(cin[8:7]), .tag_dirty(cin[6:5]), .tag_perr_in(cin[4]),
    .data_err_in(cin[3]), .cache_hit(hit), .hit_set(hs),
    .store_offchip(off), .tag_err_report(terr), .data_err_report(derr),
    .fill_valid(cin[2]), .store_write(cin[1]), .tag_parity_in(cin[0]),
    .data_write_en(dwe), .ecc_write_en(ewe), .tag_write_en(twe),
    .tag_parity_out(tpo));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [63:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, exp);
  endtask

  // status read plus the mode outputs
  task automatic st(input logic [63:0] exp);
    rd(8'h10, exp);
    chk("mode", {rr, sr, pr, cm}, {4{exp[8]}});
  endtask

  task automatic ev(input logic mp, rt, input int n);
    repeat (n)
    begin
      @(posedge clk);
      bm <= mp;
      cr <= rt;
    end
    @(posedge clk);
    bm <= 1'b0;
    cr <= 1'b0;
  endtask

  task automatic tr(input logic [47:0] v, input logic [31:0] exp);
    @(posedge clk);
    va_valid <= 1'b1;
    va <= v;
    @(posedge clk);
    va_valid <= 1'b0;
    #1 chk("xlate", {sp_hit, sp_pfn}, exp);
  endtask

  // one lookup/write cycle, outputs one cycle later
  task automatic cy(input logic [11:0] i, input logic [9:0] exp);
    @(posedge clk);
    cin <= i;
    @(posedge clk);
    cin <= 12'h000;
    #1 chk("cache", {hit, hs, off, terr, derr, dwe, ewe, twe, tpo}, exp);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (4000) @(posedge clk);
    err_total++;
    finish_test;
  end

  initial
  begin
    {resetn, reg_wr, reg_rd, bm, cr, va_valid} = 6'h00;
    cin = 12'h000;
    reg_addr = 8'h00;
    reg_wdata = 64'h0;
    va = 48'h0;
    vas[0] = {18'h3fffe, 30'h2345_6789};
    vas[1] = {7'h7e, 41'h1_3579_bdf0};
    vas[2] = {4'hb, 44'h9_8765_4321_0};
    pf[0] = {14'h0, vas[0][29:13]};
    pf[1] = {{3{vas[1][40]}}, vas[1][40:13]};
    pf[2] = vas[2][43:13];
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    st(64'h0);
    rd(8'h00, 64'h0);
    rd(8'h08, 64'h0);
    wr(8'h18, 64'hffff_ffff_ffff_ffff);
    rd(8'h18, 64'h0);
    st(64'h0);
    cy(12'hd9d, 10'h38f);
    wr(8'h00, 64'h20);
    ev(1'b1, 1'b0, 32);
    st(64'h580);
    ev(1'b0, 1'b1, 4);
    st(64'h47c);
    wr(8'h00, 64'h30);
    ev(1'b1, 1'b0, 1);
    st(64'h784);
    ev(1'b1, 1'b1, 30);
    st(64'h7ff);
    ev(1'b0, 1'b1, 300);
    st(64'h600);
    wr(8'h00, 64'h10);
    ev(1'b1, 1'b0, 5);
    st(64'h300);
    wr(8'h00, 64'h00);
    ev(1'b1, 1'b0, 40);
    st(64'h000);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h00, 64'h2 << i);
      for (int j = 0; j < 3; j++)
        tr(vas[j], i == j ? {1'b1, pf[j]} : 32'h0);
    end
    wr(8'h08, 64'h85);
    cy(12'he08, 10'h2d0);
    cy(12'he28, 10'h290);
    cy(12'h800, 10'h000);
    wr(8'h08, 64'h71);
    cy(12'hd1c, 10'h02b);
    cy(12'h003, 10'h008);
    wr(8'h08, 64'h00);
    cy(12'hc80, 10'h280);
    wr(8'h00, 64'h1e);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    st(64'h000);
    tr(vas[2], 32'h0);
    cy(12'hd80, 10'h380);
    finish_test;
  end
endmodule
